/* rtl/adcsc_defs.svh */
// Offsets, field positions, reset values and timing counts for the
// converter status/control block. Included by the control module and the bench.
`ifndef ADCSC_DEFS_SVH
`define ADCSC_DEFS_SVH

// Register indices on the plain register port
`define ADCSC_OFS_SC1      4'h0
`define ADCSC_OFS_SC2      4'h1
`define ADCSC_OFS_STAT     4'h2
`define ADCSC_OFS_RESL     4'h3

// Field positions in the first status/control register
`define ADCSC_BIT_DONE     7
`define ADCSC_BIT_IEN      6
`define ADCSC_BIT_CONT     5
`define ADCSC_CH_HI        4

// Field positions in the second control register
`define ADCSC_BIT_TRG      6
`define ADCSC_BIT_CMPE     5

// Reset values
`define ADCSC_RST_SC1      8'h1F
`define ADCSC_RST_SC2      8'h00

// Channel codes
`define ADCSC_CH_LAST_IN   5'h1B
`define ADCSC_CH_RSVD      5'h1C
`define ADCSC_CH_REFH      5'h1D
`define ADCSC_CH_REFL      5'h1E
`define ADCSC_CH_OFF       5'h1F

// Conversion time in bus cycles
`define ADCSC_CONV_CYCLES  6'h14

`endif

/* rtl/adcsc_pkg.sv */
// Types shared by the converter status/control block.
// Assumes adcsc_defs.svh is on the include path.
package adcsc_pkg;

	typedef enum logic [1:0] {
		ADCSC_IDLE,
		ADCSC_CONV,
		ADCSC_OFF
	} adcsc_state_t;

	typedef enum logic [1:0] {
		ADCSC_SRC_IN,
		ADCSC_SRC_REFH,
		ADCSC_SRC_REFL,
		ADCSC_SRC_NONE
	} adcsc_src_t;

endpackage

/* rtl/adcsc_ctrl.sv */
// Status/control register one of a 10-bit successive-approximation
// converter: done flag, interrupt, single/continuous, channel select.
// Assumes a plain register port on clk and a converter core that reports
// the end of each conversion with a one-cycle conv_end pulse.
`timescale 1ns/1ps

`include "adcsc_defs.svh"

module adcsc_ctrl
	import adcsc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Converter core
	input  wire logic       hw_trigger_in,
	input  wire logic       conv_end,
	input  wire logic       cmp_true,
	output logic            conv_start,
	output logic            conv_abort,
	output logic            conv_active,
	output logic            conv_power,
	output logic      [4:0] input_sel,
	output logic      [1:0] source_sel,
	// Interrupt
	output logic            done_irq
);

	// ------------------------------------------------------------
	// Reset release and trigger synchroniser
	// ------------------------------------------------------------
	logic       rst_s1_r;
	logic       rst_s2_r;
	logic       trg_s1_r;
	logic       trg_s2_r;
	logic       trg_s3_r;
	logic       hw_evt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			trg_s1_r <= 1'b0;
			trg_s2_r <= 1'b0;
			trg_s3_r <= 1'b0;
		end else begin
			trg_s1_r <= hw_trigger_in;
			trg_s2_r <= trg_s1_r;
			trg_s3_r <= trg_s2_r;
		end
	end

	assign hw_evt = trg_s2_r & ~trg_s3_r;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic       done_irq_enable_r;
	logic       continuous_enable_r;
	logic [4:0] channel_select_r;
	logic       trigger_select_r;
	logic       compare_enable_r;
	logic       conv_done_flag_r;
	logic       wr_sc1;
	logic       rd_resl;
	logic       done_set;

	localparam logic [7:0] RST_SC1 = `ADCSC_RST_SC1;

	assign wr_sc1  = reg_wr && reg_addr == `ADCSC_OFS_SC1;
	assign rd_resl = reg_rd && reg_addr == `ADCSC_OFS_RESL;

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			done_irq_enable_r   <= RST_SC1[`ADCSC_BIT_IEN];
			continuous_enable_r <= RST_SC1[`ADCSC_BIT_CONT];
			channel_select_r    <= RST_SC1[`ADCSC_CH_HI:0];
		end else if (wr_sc1) begin
			done_irq_enable_r   <= reg_wdata[`ADCSC_BIT_IEN];
			continuous_enable_r <= reg_wdata[`ADCSC_BIT_CONT];
			channel_select_r    <= reg_wdata[`ADCSC_CH_HI:0];
		end
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			trigger_select_r <= 1'b0;
			compare_enable_r <= 1'b0;
		end else if (reg_wr && reg_addr == `ADCSC_OFS_SC2) begin
			trigger_select_r <= reg_wdata[`ADCSC_BIT_TRG];
			compare_enable_r <= reg_wdata[`ADCSC_BIT_CMPE];
		end
	end

	// ------------------------------------------------------------
	// Conversion sequencing
	// ------------------------------------------------------------
	adcsc_state_t state_r;
	adcsc_state_t state_nxt;
	logic         ch_off;
	logic         sw_go;
	logic         hw_go;
	logic         again;
	logic         fin;

	assign ch_off = wr_sc1 && reg_wdata[`ADCSC_CH_HI:0] == `ADCSC_CH_OFF;
	assign sw_go  = wr_sc1 && !ch_off && !trigger_select_r;
	assign hw_go  = trigger_select_r && hw_evt && state_r != ADCSC_OFF;
	assign fin    = state_r == ADCSC_CONV && conv_end && !wr_sc1;
	assign again  = fin && continuous_enable_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ADCSC_IDLE: begin
				if (hw_go)
					state_nxt = ADCSC_CONV;
			end
			ADCSC_CONV: begin
				if (conv_end && !continuous_enable_r)
					state_nxt = ADCSC_IDLE;
			end
			ADCSC_OFF: begin
				state_nxt = ADCSC_OFF;
			end
		endcase
		if (wr_sc1) begin
			if (ch_off)
				state_nxt = ADCSC_OFF;
			else if (!trigger_select_r)
				state_nxt = ADCSC_CONV;
			else
				state_nxt = ADCSC_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r)
			state_r <= ADCSC_OFF;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			conv_start  <= 1'b0;
			conv_abort  <= 1'b0;
			conv_active <= 1'b0;
			conv_power  <= 1'b0;
		end else begin
			conv_start  <= sw_go
				|| (state_r == ADCSC_IDLE && hw_go && !wr_sc1) || again;
			conv_abort  <= wr_sc1 && state_r == ADCSC_CONV;
			conv_active <= state_nxt == ADCSC_CONV;
			conv_power  <= state_nxt == ADCSC_CONV;
		end
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			input_sel  <= 5'h00;
			source_sel <= ADCSC_SRC_NONE;
		end else begin
			input_sel <= (channel_select_r <= `ADCSC_CH_LAST_IN) ?
				channel_select_r : 5'h00;
			if (channel_select_r <= `ADCSC_CH_LAST_IN)
				source_sel <= ADCSC_SRC_IN;
			else if (channel_select_r == `ADCSC_CH_REFH)
				source_sel <= ADCSC_SRC_REFH;
			else if (channel_select_r == `ADCSC_CH_REFL)
				source_sel <= ADCSC_SRC_REFL;
			else
				source_sel <= ADCSC_SRC_NONE;
		end
	end

	// ------------------------------------------------------------
	// Done flag and interrupt
	// ------------------------------------------------------------
	// set condition
	assign done_set = fin && (!compare_enable_r || cmp_true);

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r)
			conv_done_flag_r <= 1'b0;
		else if (done_set)
			conv_done_flag_r <= 1'b1;
		// clear on write or low read
		else if (wr_sc1 || rd_resl)
			conv_done_flag_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r)
			done_irq <= 1'b0;
		else
			done_irq <= (done_set || (conv_done_flag_r && !wr_sc1
				&& !rd_resl)) && done_irq_enable_r;
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			unique case (reg_addr)
				`ADCSC_OFS_SC1: reg_rdata <= {conv_done_flag_r,
					done_irq_enable_r, continuous_enable_r,
					channel_select_r};
				`ADCSC_OFS_SC2: reg_rdata <= {state_r == ADCSC_CONV,
					trigger_select_r, compare_enable_r, 5'h00};
				`ADCSC_OFS_STAT: reg_rdata <= {6'h00, conv_power,
					conv_active};
				default: reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_abort;
		@(posedge clk) disable iff (!rst_s2_r)
		wr_sc1 && state_r == ADCSC_CONV |=> conv_abort;
	endproperty
	a_abort: assert property (p_abort) else $error("no abort");

	property p_no_ro_set;
		@(posedge clk) disable iff (!rst_s2_r)
		wr_sc1 && !done_set |=> !conv_done_flag_r;
	endproperty
	a_no_ro_set: assert property (p_no_ro_set) else $error("flag set");

	property p_set_nocmp;
		@(posedge clk) disable iff (!rst_s2_r)
		fin && !compare_enable_r |=> conv_done_flag_r;
	endproperty
	a_set_nocmp: assert property (p_set_nocmp) else $error("no set");

	property p_set_cmp;
		@(posedge clk) disable iff (!rst_s2_r)
		$rose(conv_done_flag_r) |-> $past(compare_enable_r) ?
			$past(cmp_true) : 1'b1;
	endproperty
	a_set_cmp: assert property (p_set_cmp) else $error("cmp set");

	property p_clear;
		@(posedge clk) disable iff (!rst_s2_r)
		rd_resl && !done_set |=> !conv_done_flag_r;
	endproperty
	a_clear: assert property (p_clear) else $error("no clear");

	property p_irq;
		@(posedge clk) disable iff (!rst_s2_r)
		done_irq |-> conv_done_flag_r && done_irq_enable_r;
	endproperty
	a_irq: assert property (p_irq) else $error("bad irq");

	property p_off;
		@(posedge clk) disable iff (!rst_s2_r)
		ch_off |=> !conv_power && !conv_start;
	endproperty
	a_off: assert property (p_off) else $error("not off");

	property p_lowpow;
		@(posedge clk) disable iff (!rst_s2_r)
		fin && !continuous_enable_r && !hw_go |=> !conv_power;
	endproperty
	a_lowpow: assert property (p_lowpow) else $error("powered");

	c_done: cover property (@(posedge clk) $rose(conv_done_flag_r));
	c_irq:  cover property (@(posedge clk) $rose(done_irq));
	c_hw:   cover property (@(posedge clk) hw_go && state_r == ADCSC_IDLE);

endmodule

/* bench/adcsc_ctrl_test.sv */
// Self-checking bench for the register-one converter control block.
// Drives the register port and the core inputs directly, one clock.
`timescale 1ns/1ps
`include "adcsc_defs.svh"
module adcsc_ctrl_test
	import adcsc_pkg::*;
;
	logic       clk, rst_n, reg_wr, reg_rd;
	logic       hw_trigger_in, conv_end, cmp_true;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv, wd;
	logic       conv_start, conv_abort, conv_active, conv_power;
	logic       done_irq, ien;
	logic [4:0] input_sel;
	logic [1:0] source_sel;
	int         err_total, checks_done, cycles, seed;

	adcsc_ctrl uut (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .hw_trigger_in(hw_trigger_in),
		.conv_end(conv_end), .cmp_true(cmp_true),
		.conv_start(conv_start), .conv_abort(conv_abort),
		.conv_active(conv_active), .conv_power(conv_power),
		.input_sel(input_sel), .source_sel(source_sel),
		.done_irq(done_irq)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Returns just after the edge that took the strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic fin(input logic c);
		@(posedge clk);
		conv_end <= 1'b1;
		cmp_true <= c;
		@(posedge clk);
		conv_end <= 1'b0;
		#1;
	endtask

	// Counts start pulses, first sample in the current cycle
	task automatic quiet(input int n, input string nm);
		int s;
		s = 0;
		repeat (n) begin
			s += conv_start;
			@(posedge clk);
			#1;
		end
		chk(nm, 8'(s), 8'h00);
	endtask

	// Trigger is held long enough for the synchroniser, then low again
	task automatic hw_go(input string nm, input logic [7:0] exp);
		int s;
		s = 0;
		@(posedge clk);
		hw_trigger_in <= 1'b1;
		repeat (8) begin
			@(posedge clk);
			#1;
			s += conv_start;
		end
		@(posedge clk);
		hw_trigger_in <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk(nm, 8'(s), exp);
	endtask

	function automatic logic [7:0] src_exp(input logic [4:0] c);
		case (c)
			`ADCSC_CH_REFH: src_exp = 8'h01;
			`ADCSC_CH_REFL: src_exp = 8'h02;
			`ADCSC_CH_OFF:  src_exp = 8'h03;
			default:        src_exp = 8'h00;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Clock, timeout, sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			test_done;
		end
	end

	initial begin
		seed = 32'h870D3B39;
		{rst_n, reg_wr, reg_rd, hw_trigger_in, conv_end, cmp_true} = 6'h00;
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		rd(`ADCSC_OFS_SC1, rv);
		chk("sc1 reset", rv, `ADCSC_RST_SC1);
		rd(`ADCSC_OFS_SC2, rv);
		chk("sc2 reset", rv, `ADCSC_RST_SC2);
		chk("src reset", {6'h00, source_sel}, 8'h03);
		rd(4'hF, rv);
		chk("unmapped", rv, 8'h00);
		$display("test reset done");

		for (int c = 0; c < 31; c++) begin
			if (c == 28)
				continue;
			rv  = $random(seed);
			ien = rv[6];
			wd  = {rv[7], ien, 1'b0, c[4:0]};
			wr(`ADCSC_OFS_SC1, wd);
			chk("start", {7'h00, conv_start}, 8'h01);
			chk("power", {7'h00, conv_power}, 8'h01);
			chk("active", {7'h00, conv_active}, 8'h01);
			rd(`ADCSC_OFS_SC1, rv);
			chk("sc1 wr", rv, {1'b0, wd[6:0]});
			if (c < 28)
				chk("input", {3'h0, input_sel}, 8'(c));
			chk("source", {6'h00, source_sel}, src_exp(c[4:0]));
			fin(rv[0] ^ rv[3]);
			chk("irq", {7'h00, done_irq}, {7'h00, ien});
			chk("low power", {7'h00, conv_power}, 8'h00);
			chk("idle", {7'h00, conv_active}, 8'h00);
			quiet(3, "single");
			if (c[0])
				rd(`ADCSC_OFS_RESL, rv);
			rd(`ADCSC_OFS_SC1, rv);
			chk("flag", rv, {~c[0], wd[6:0]});
		end
		$display("test channels done");

		wr(`ADCSC_OFS_SC1, 8'h22);
		rd(`ADCSC_OFS_STAT, rv);
		chk("stat run", rv, 8'h03);
		fin(1'b0);
		chk("cont", {7'h00, conv_start}, 8'h01);
		wr(`ADCSC_OFS_SC1, 8'h24);
		chk("abort", {7'h00, conv_abort}, 8'h01);
		chk("restart", {7'h00, conv_start}, 8'h01);
		wr(`ADCSC_OFS_SC1, 8'h3F);
		chk("abort off", {7'h00, conv_abort}, 8'h01);
		chk("off power", {7'h00, conv_power}, 8'h00);
		quiet(6, "off");
		chk("off src", {6'h00, source_sel}, 8'h03);
		rd(`ADCSC_OFS_STAT, rv);
		chk("stat off", rv, 8'h00);
		$display("test continuous done");

		wr(`ADCSC_OFS_SC2, 8'h20);
		wr(`ADCSC_OFS_SC1, 8'h41);
		fin(1'b0);
		chk("cmp false", {7'h00, done_irq}, 8'h00);
		rd(`ADCSC_OFS_SC1, rv);
		chk("cmp flag", rv, 8'h41);
		wr(`ADCSC_OFS_SC1, 8'h41);
		fin(1'b1);
		chk("cmp true", {7'h00, done_irq}, 8'h01);
		rd(`ADCSC_OFS_SC2, rv);
		chk("sc2", rv, 8'h20);
		$display("test compare done");

		wr(`ADCSC_OFS_SC2, 8'h40);
		wr(`ADCSC_OFS_SC1, 8'h43);
		chk("no sw start", {7'h00, conv_start}, 8'h00);
		hw_go("hw start", 8'h01);
		rd(`ADCSC_OFS_SC2, rv);
		chk("sc2 active", rv, 8'hC0);
		hw_go("hw busy", 8'h00);
		fin(1'b1);
		rd(`ADCSC_OFS_SC1, rv);
		chk("hw flag", rv, 8'hC3);
		hw_go("hw again", 8'h01);
		fin(1'b0);
		wr(`ADCSC_OFS_SC1, 8'h23);
		hw_go("hw cont", 8'h01);
		fin(1'b0);
		chk("hw cont", {7'h00, conv_start}, 8'h01);
		wr(`ADCSC_OFS_SC1, 8'h1F);
		$display("test hardware trigger done");
		test_done;
	end
endmodule
